// [eibc_core.sv]
// Two-wire slave bus-condition front end of a small serial EEPROM
`default_nettype none

module eibc_core #(
  parameter int PROG_CYCLES = eibc_pkg::PROG_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [7:0] tx_data,
  output logic [7:0] rx_data,
  output logic rx_strobe,
  output logic rx_first,
  output logic prog_start,
  output logic prog_busy,
  output logic standby
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_ACTIVE,
    ST_PROG
  } eibc_state_e;

  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);

  eibc_state_e state_reg;
  eibc_state_e state_next;
  logic [1:0] bus_sync;
  logic [2:0] link_sync;
  logic scl_d_reg;
  logic sda_d_reg;
  logic tgl_d_reg;
  logic link_clear_reg;
  logic [CW-1:0] prog_cnt_reg;
  logic [7:0] tx_hold_reg;
  logic start_det;
  logic stop_det;
  logic byte_evt;
  // Link-domain state
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] rx_byte_reg;
  logic [7:0] tx_shift_reg;
  logic [1:0] byte_idx_reg;
  logic first_reg;
  logic rd_reg;
  logic nack_reg;
  logic wr_data_reg;
  logic byte_tgl_reg;

  // ----------------------------------------------------------------
  // Bus condition detection on the system clock
  // ----------------------------------------------------------------
  eibc_sync #(.WIDTH(2)) u_bus_sync (
    .clock(clock),
    .srst(srst),
    .async_in({scl, sda_i}),
    .sync_reg(bus_sync)
  );

  // Link levels are stable for many bus bit times before being read
  eibc_sync #(.WIDTH(3)) u_link_sync (
    .clock(clock),
    .srst(srst),
    .async_in({byte_tgl_reg, wr_data_reg, nack_reg}),
    .sync_reg(link_sync)
  );

  always_ff @(posedge clock) begin
    if (srst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      tgl_d_reg <= 1'b0;
    end else begin
      scl_d_reg <= bus_sync[1];
      sda_d_reg <= bus_sync[0];
      tgl_d_reg <= link_sync[2];
    end
  end

  assign start_det = bus_sync[1] & scl_d_reg & sda_d_reg & ~bus_sync[0];
  assign stop_det = bus_sync[1] & scl_d_reg & ~sda_d_reg & bus_sync[0];
  assign byte_evt = (state_reg == ST_ACTIVE) && (link_sync[2] != tgl_d_reg);

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_det) begin
          state_next = ST_ARM;
        end
      end
      ST_ARM: begin
        if (stop_det) begin
          state_next = ST_IDLE;
        end else if (!bus_sync[1]) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (start_det) begin
          state_next = ST_ARM;
        end else if (stop_det) begin
          state_next = link_sync[1] ? ST_PROG : ST_IDLE;
        end else if (link_sync[0]) begin
          state_next = ST_IDLE;
        end
      end
      ST_PROG: begin
        if (prog_cnt_reg == PROG_LAST) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Link logic is held cleared outside a frame and while busy
  always_ff @(posedge clock) begin
    if (srst) begin
      link_clear_reg <= 1'b1;
    end else begin
      link_clear_reg <= (state_next != ST_ACTIVE);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      prog_cnt_reg <= '0;
    end else if (state_reg == ST_PROG) begin
      prog_cnt_reg <= prog_cnt_reg + CW'(1);
    end else begin
      prog_cnt_reg <= '0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      prog_start <= 1'b0;
      prog_busy <= 1'b0;
      standby <= 1'b1;
      sda_o <= 1'b0;
    end else begin
      prog_start <= (state_reg == ST_ACTIVE) && (state_next == ST_PROG);
      prog_busy <= (state_next == ST_PROG);
      standby <= (state_next == ST_IDLE);
      sda_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Byte hand-over to and from the user side
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_data <= '0;
      rx_first <= 1'b0;
      rx_strobe <= 1'b0;
    end else begin
      rx_strobe <= byte_evt;
      if (byte_evt) begin
        rx_data <= rx_byte_reg;
        rx_first <= first_reg;
      end
    end
  end

  // Next read byte is sampled long before the ack clock falls
  always_ff @(posedge clock) begin
    if (srst) begin
      tx_hold_reg <= 8'hff;
    end else if (rx_strobe) begin
      tx_hold_reg <= tx_data;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: rising edges sample, falling edges drive
  // ----------------------------------------------------------------
  // Clear is released only while the clock is low, well before a rise
  always_ff @(posedge scl or posedge link_clear_reg) begin
    if (link_clear_reg) begin
      bit_cnt_reg <= eibc_pkg::BIT_FIRST;
      shift_reg <= '0;
      rx_byte_reg <= '0;
      byte_idx_reg <= eibc_pkg::IDX_SELECT;
      first_reg <= 1'b1;
      rd_reg <= 1'b0;
      nack_reg <= 1'b0;
      wr_data_reg <= 1'b0;
      byte_tgl_reg <= 1'b0;
    end else if (bit_cnt_reg == eibc_pkg::BIT_ACK) begin
      bit_cnt_reg <= eibc_pkg::BIT_FIRST;
      first_reg <= 1'b0;
      if (rd_reg && !first_reg && sda_i) begin
        nack_reg <= 1'b1;
      end
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      shift_reg <= {shift_reg[6:0], sda_i};
      if (bit_cnt_reg == eibc_pkg::BIT_LAST_DATA) begin
        rx_byte_reg <= {shift_reg[6:0], sda_i};
        byte_tgl_reg <= ~byte_tgl_reg;
        if (first_reg) begin
          rd_reg <= (sda_i == eibc_pkg::DIR_READ);
        end else if (!rd_reg) begin
          if (byte_idx_reg != eibc_pkg::IDX_DATA) begin
            byte_idx_reg <= byte_idx_reg + 2'h1;
          end
          if (byte_idx_reg != eibc_pkg::IDX_SELECT) begin
            wr_data_reg <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(negedge scl or posedge link_clear_reg) begin
    if (link_clear_reg) begin
      sda_oe <= 1'b0;
      tx_shift_reg <= '0;
    end else if (bit_cnt_reg == eibc_pkg::BIT_ACK) begin
      sda_oe <= first_reg | ~rd_reg;
    end else if (rd_reg && !first_reg && !nack_reg) begin
      if (bit_cnt_reg == eibc_pkg::BIT_FIRST) begin
        sda_oe <= ~tx_hold_reg[7];
        tx_shift_reg <= {tx_hold_reg[6:0], 1'b0};
      end else begin
        sda_oe <= ~tx_shift_reg[7];
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      end
    end else begin
      sda_oe <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// [eibc_sync.sv]
// Shared constants and the two-flop level synchronizer
`default_nettype none

package eibc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_WRITE_NS = 10000000;
  localparam int PROG_CYCLES = T_WRITE_NS / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Byte framing
  // ----------------------------------------------------------------
  localparam int DATA_BITS = 8;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic DIR_READ = 1'b1;
  localparam logic [1:0] IDX_SELECT = 2'h0;
  localparam logic [1:0] IDX_ADDRESS = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
endpackage

module eibc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_reg
);
  logic [WIDTH-1:0] stage_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      stage_reg <= '0;
      sync_reg <= '0;
    end else begin
      stage_reg <= async_in;
      sync_reg <= stage_reg;
    end
  end
endmodule

`default_nettype wire

// [eibc_core_assertions.sv]
// Port checks for the bus-condition front end
`default_nettype none
module eibc_core_assertions #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic rx_strobe,
  input wire logic prog_start,
  input wire logic prog_busy,
  input wire logic standby
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] busy_cnt_reg;
  always_ff @(posedge clock) begin
    if (srst || !prog_busy) begin
      busy_cnt_reg <= 32'h0;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 32'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_go;
    prog_start ##[0:1] prog_busy;
  endsequence
  sequence s_done;
    ##[0:2] standby;
  endsequence
  a_sda_low: assert property (!sda_o)
    else $error("data pin driven high");
  a_busy_quiet: assert property (prog_busy |-> !sda_oe)
    else $error("drive while busy");
  a_busy_norx: assert property (prog_busy |-> !rx_strobe)
    else $error("byte taken while busy");
  a_busy_stby: assert property (prog_busy |-> !standby)
    else $error("standby while busy");
  a_prog_go: assert property (prog_start |-> s_go)
    else $error("no busy after launch");
  a_prog_pulse: assert property (prog_start |=> !prog_start)
    else $error("launch pulse too long");
  a_busy_len: assert property (
    $fell(prog_busy) |-> busy_cnt_reg == PROG_CYCLES)
    else $error("busy length wrong");
  a_busy_done: assert property ($fell(prog_busy) |-> s_done)
    else $error("no standby after busy");
  a_stby_idle: assert property (standby |-> !sda_oe)
    else $error("drive in standby");
  a_rx_pulse: assert property (rx_strobe |=> !rx_strobe)
    else $error("byte strobe too long");
endmodule
bind eibc_core eibc_core_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .clock(clock), .srst(srst), .sda_o(sda_o), .sda_oe(sda_oe),
  .rx_strobe(rx_strobe), .prog_start(prog_start),
  .prog_busy(prog_busy), .standby(standby));
`default_nettype wire

// [eibc_master.sv]
// Behavioural two-wire bus master; clock idles high between frames
`default_nettype none
module eibc_master (
  input wire logic lclk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Third of a bit, long enough for the synchronizers
  task automatic q;
    repeat (8) @(posedge lclk);
  endtask
  // Clock low with data released, so loose bits never frame a start
  task automatic park;
    scl <= 1'b0;
    q;
  endtask
  task automatic start;
    sda_low <= 1'b0;
    q;
    scl <= 1'b1;
    q;
    sda_low <= 1'b1;
    q;
    scl <= 1'b0;
    q;
  endtask
  task automatic stop;
    sda_low <= 1'b1;
    q;
    scl <= 1'b1;
    q;
    sda_low <= 1'b0;
    q;
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_low <= ~b;
    q;
    scl <= 1'b1;
    q;
    r = sda;
    scl <= 1'b0;
    q;
  endtask
  // Ninth bit 1 releases the wire for the other side
  task automatic byte_x(input logic [7:0] d, input logic a,
                        output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
    bit_x(a, k);
  endtask
endmodule
`default_nettype wire

// [eibc_core_tb.sv]
// Self-checking bench for the bus-condition front end
`default_nettype none
module eibc_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, lclk, srst, scl, sda_low, sda_oe, sda_o, sda, k;
  logic rx_strobe, rx_first, prog_start, prog_busy, standby;
  logic [7:0] tx_data, rx_data, rd;
  logic [8:0] exp_q[$];
  int num_errors, tests_run, n_prog;
  // Open drain with pull-up
  assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;
  eibc_core #(.PROG_CYCLES(400)) u_eibc_core (.clock(clock),
    .srst(srst), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .tx_data(tx_data), .rx_data(rx_data),
    .rx_strobe(rx_strobe), .rx_first(rx_first),
    .prog_start(prog_start), .prog_busy(prog_busy), .standby(standby));
  eibc_master u_eibc_master (.lclk(lclk), .sda(sda), .scl(scl),
    .sda_low(sda_low));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #16 lclk = ~lclk;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] d, input logic f);
    exp_q.push_back({f, d});
    u_eibc_master.byte_x(d, 1'b1, rd, k);
    chk({8'h0, k}, 9'h0);
  endtask
  // Unexpected byte always counts, even when its data is unknown
  always @(negedge clock) begin
    if (rx_strobe === 1'b1) begin
      if (exp_q.size() == 0) chk(9'h1, 9'h0);
      else chk({rx_first, rx_data}, exp_q.pop_front());
    end
    if (prog_start === 1'b1) n_prog++;
  end
  initial begin
    #900us;
    num_errors++;
    stop_test;
  end
  initial begin
    srst = 1'b1;
    tx_data = 8'h0;
    void'($urandom(32'hda31));
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    repeat (4) @(posedge clock);
    u_eibc_master.park;
    repeat (9) u_eibc_master.bit_x(1'($urandom), k);
    u_eibc_master.stop;
    u_eibc_master.start;
    wr(8'ha0, 1'b1);
    wr(8'h00, 1'b0);
    wr(8'($urandom), 1'b0);
    u_eibc_master.stop;
    chk({7'h0, prog_busy, standby}, 9'h2);
    u_eibc_master.start;
    u_eibc_master.byte_x(8'ha0, 1'b1, rd, k);
    chk({8'h0, k}, 9'h1);
    u_eibc_master.stop;
    for (int i = 0; i < 1000 && prog_busy !== 1'b0; i++) @(posedge clock);
    repeat (2) @(posedge clock);
    chk({8'h0, standby}, 9'h1);
    @(posedge clock);
    tx_data <= 8'($urandom);
    u_eibc_master.start;
    wr(8'ha1, 1'b1);
    exp_q.push_back({1'b0, tx_data});
    u_eibc_master.byte_x(8'hff, 1'b0, rd, k);
    chk({1'b0, rd}, {1'b0, tx_data});
    exp_q.push_back({1'b0, tx_data});
    u_eibc_master.byte_x(8'hff, 1'b1, rd, k);
    chk({1'b0, rd}, {1'b0, tx_data});
    chk({8'h0, standby}, 9'h1);
    u_eibc_master.stop;
    chk({8'h0, standby}, 9'h1);
    u_eibc_master.start;
    repeat (3) u_eibc_master.bit_x(1'b1, k);
    u_eibc_master.start;
    wr(8'ha0, 1'b1);
    wr(8'($urandom), 1'b0);
    u_eibc_master.stop;
    repeat (10) @(posedge clock);
    chk({8'h0, standby}, 9'h1);
    chk(9'(n_prog), 9'h1);
    chk(9'(exp_q.size()), 9'h0);
    stop_test;
  end
endmodule
`default_nettype wire
